// >>> hw/psg_consts.vh
// Constants for the power stage reset and undervoltage guard.
// Assumes a 40 MHz system clock and 32-bit APB register access.
`ifndef PSG_CONSTS_VH
`define PSG_CONSTS_VH

`define PSG_ADDR_W 12
`define PSG_OFF_CTRL 12'h000
`define PSG_OFF_STATUS 12'h004
`define PSG_OFF_IRQ_STAT 12'h008
`define PSG_OFF_IRQ_MASK 12'h00C

// Control register fields
`define PSG_CTRL_MODE_LSB 0
`define PSG_CTRL_RESET 2'h0

// Output mode codes
`define PSG_MODE_BRIDGED 2'h0
`define PSG_MODE_PARALLEL 2'h1
`define PSG_MODE_SINGLE 2'h2

// Status register fields
`define PSG_ST_SUPPLY_LOW 0
`define PSG_ST_OVERTEMP 1
`define PSG_ST_OVL_ONE 2
`define PSG_ST_OVL_TWO 3
`define PSG_ST_FAULT_N 4
`define PSG_ST_POR_DONE 5

// Interrupt event bits
`define PSG_IRQ_W 4
`define PSG_IRQ_SUPPLY 0
`define PSG_IRQ_OVERTEMP 1
`define PSG_IRQ_OVL_ONE 2
`define PSG_IRQ_OVL_TWO 3
`define PSG_IRQ_RESET 4'h0

`endif

// >>> hw/psg_guard.v
// Protection and reset control for a four half-bridge power stage.
// Assumes supply and fault detector levels arrive asynchronously on pins
// and that the modulator keeps the minimum reset spacing after a fault.
`timescale 1ns/1ps
`include "psg_consts.vh"

module psg_guard #(
    parameter ADDR_W = `PSG_ADDR_W
) (
    input wire mclk_in,
    input wire sys_rst_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [ADDR_W-1:0] paddr_in,
    input wire [31:0] pwdata_in,
    input wire [3:0] pstrb_in,
    output wire pready_out,
    output reg [31:0] prdata_out,
    output wire pslverr_out,
    input wire pair_one_hold_n_in,
    input wire pair_two_hold_n_in,
    input wire gate_drive_supply_ok_in,
    input wire core_supply_ok_in,
    input wire overtemp_in,
    input wire overload_one_in,
    input wire overload_two_in,
    input wire [3:0] pwm_in,
    output reg [3:0] high_side_on_out,
    output reg [3:0] low_side_on_out,
    output reg [3:0] weak_pulldown_out,
    output reg fault_flag_n_out,
    output wire irq_out
);

    // Two-stage synchronisers for all pin inputs
    localparam NSYNC = 11;
    reg [NSYNC-1:0] sync1_reg;
    reg [NSYNC-1:0] sync2_reg;
    wire [NSYNC-1:0] pins_raw;
    assign pins_raw = {pwm_in, overload_two_in, overload_one_in, overtemp_in,
                       core_supply_ok_in, gate_drive_supply_ok_in,
                       pair_two_hold_n_in, pair_one_hold_n_in};

    always @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sync1_reg <= 11'h003;
            sync2_reg <= 11'h003;
        end else begin
            sync1_reg <= pins_raw;
            sync2_reg <= sync1_reg;
        end
    end

    wire hold_one_n = sync2_reg[0];
    wire hold_two_n = sync2_reg[1];
    wire gate_ok = sync2_reg[2];
    wire core_ok = sync2_reg[3];
    wire ot_det = sync2_reg[4];
    wire ovl_one_det = sync2_reg[5];
    wire ovl_two_det = sync2_reg[6];
    wire [3:0] pwm_s = sync2_reg[10:7];

    // Previous hold levels for edge detection
    reg hold_one_d_reg;
    reg hold_two_d_reg;
    reg por_done_reg;
    reg overload_latch_one_reg;
    reg overload_latch_two_reg;
    reg overtemp_error_latch_reg;
    reg [1:0] mode_reg;
    reg [`PSG_IRQ_W-1:0] irq_stat_reg;
    reg [`PSG_IRQ_W-1:0] irq_mask_reg;

    wire supply_low_guard = ~(gate_ok & core_ok);
    wire hold_rise = (hold_one_n & ~hold_one_d_reg) |
                     (hold_two_n & ~hold_two_d_reg);
    wire any_hold = ~hold_one_n | ~hold_two_n;
    wire single_ended_mode = (mode_reg == `PSG_MODE_SINGLE);

    always @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            hold_one_d_reg <= 1'b1;
            hold_two_d_reg <= 1'b1;
        end else begin
            hold_one_d_reg <= hold_one_n;
            hold_two_d_reg <= hold_two_n;
        end
    end

    always @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            por_done_reg <= 1'b0;
        end else if (gate_ok & core_ok) begin
            por_done_reg <= 1'b1;
        end
    end

    always @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            overload_latch_one_reg <= 1'b0;
            overload_latch_two_reg <= 1'b0;
        end else if (~por_done_reg) begin
            overload_latch_one_reg <= 1'b0;
            overload_latch_two_reg <= 1'b0;
        end else if (hold_rise) begin
            overload_latch_one_reg <= 1'b0;
            overload_latch_two_reg <= 1'b0;
        end else begin
            if (ovl_one_det & hold_one_n) begin
                overload_latch_one_reg <= 1'b1;
            end
            if (ovl_two_det & hold_two_n) begin
                overload_latch_two_reg <= 1'b1;
            end
        end
    end

    // overtemperature latch, cleared while a hold is low
    always @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            overtemp_error_latch_reg <= 1'b0;
        end else if (ot_det) begin
            overtemp_error_latch_reg <= 1'b1;
        end else if (any_hold) begin
            overtemp_error_latch_reg <= 1'b0;
        end
    end

    // self recovery for supply faults; the overtemp latch needs a hold to clear
    // Supply low gates the stage only while it lasts; nothing latches it
    wire global_off = supply_low_guard | ~por_done_reg |
                      overtemp_error_latch_reg;

    // Spreads one flag per pair over that pair's two half-bridges
    function [3:0] pair_spread;
        input first_pair;
        input second_pair;
        begin
            pair_spread = {second_pair, second_pair, first_pair, first_pair};
        end
    endfunction

    // Register offset match, shared by write strobes and slave error
    function reg_sel;
        input [ADDR_W-1:0] addr;
        input [ADDR_W-1:0] offset;
        begin
            reg_sel = (addr == offset);
        end
    endfunction

    wire off_one = global_off | ~hold_one_n | overload_latch_one_reg;
    wire off_two = global_off | ~hold_two_n | overload_latch_two_reg;
    wire [3:0] hb_off = pair_spread(off_one, off_two);

    wire [3:0] hb_held = pair_spread(~hold_one_n, ~hold_two_n);
    wire any_fault = global_off | overload_latch_one_reg |
                     overload_latch_two_reg;

    reg [3:0] high_side_next;
    reg [3:0] low_side_next;
    reg [3:0] pulldown_next;
    reg fault_flag_n_next;

    always @* begin
        high_side_next = pwm_s & ~hb_off;
        low_side_next = ~pwm_s & ~hb_off;
        if (single_ended_mode) begin
            pulldown_next = 4'h0;
        end else begin
            pulldown_next = hb_held;
        end
        if (any_hold) begin
            fault_flag_n_next = 1'b1;
        end else begin
            fault_flag_n_next = ~any_fault;
        end
    end

    always @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            high_side_on_out <= 4'h0;
            low_side_on_out <= 4'h0;
            weak_pulldown_out <= 4'h0;
            fault_flag_n_out <= 1'b0;
        end else begin
            high_side_on_out <= high_side_next;
            low_side_on_out <= low_side_next;
            weak_pulldown_out <= pulldown_next;
            fault_flag_n_out <= fault_flag_n_next;
        end
    end

    // APB slave with one wait state, so read data comes from a flop
    reg ready_reg;
    wire [ADDR_W-1:0] off = paddr_in;
    wire access = psel_in & penable_in;
    wire hit = reg_sel(off, `PSG_OFF_CTRL) |
               reg_sel(off, `PSG_OFF_STATUS) |
               reg_sel(off, `PSG_OFF_IRQ_STAT) |
               reg_sel(off, `PSG_OFF_IRQ_MASK);
    wire rd_capture = access & ~ready_reg & ~pwrite_in;
    // Write strobes act only at the completing edge
    wire apb_wr = access & ready_reg & pwrite_in & pstrb_in[0];
    wire wr_ctrl = apb_wr & reg_sel(off, `PSG_OFF_CTRL);
    wire wr_mask = apb_wr & reg_sel(off, `PSG_OFF_IRQ_MASK);
    wire wr_stat = apb_wr & reg_sel(off, `PSG_OFF_IRQ_STAT);
    assign pready_out = ready_reg;
    assign pslverr_out = access & ready_reg & ~hit;

    // Pready rises one cycle into the access phase
    always @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ready_reg <= 1'b0;
        end else begin
            ready_reg <= access & ~ready_reg;
        end
    end

    // Supply events count only after power-on clear
    wire supply_event = supply_low_guard & por_done_reg;
    wire [`PSG_IRQ_W-1:0] irq_event = {overload_latch_two_reg,
                                       overload_latch_one_reg,
                                       overtemp_error_latch_reg,
                                       supply_event};
    // Clear uses write data as a one-per-bit mask
    wire [`PSG_IRQ_W-1:0] irq_clr = wr_stat ?
        pwdata_in[`PSG_IRQ_W-1:0] : 4'h0;

    always @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            mode_reg <= `PSG_CTRL_RESET;
            irq_mask_reg <= `PSG_IRQ_RESET;
            irq_stat_reg <= `PSG_IRQ_RESET;
        end else begin
            if (wr_ctrl) begin
                mode_reg <= pwdata_in[1:0];
            end
            if (wr_mask) begin
                irq_mask_reg <= pwdata_in[`PSG_IRQ_W-1:0];
            end
            // Set wins over a same-cycle clear
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_event;
        end
    end

    assign irq_out = |(irq_stat_reg & irq_mask_reg);

    wire [31:0] status_word = {26'h0, por_done_reg, fault_flag_n_out,
                               overload_latch_two_reg, overload_latch_one_reg,
                               overtemp_error_latch_reg, supply_low_guard};

    reg [31:0] read_next;

    always @* begin
        read_next = 32'h0;
        case (off)
            `PSG_OFF_CTRL: read_next = {30'h0, mode_reg};
            `PSG_OFF_STATUS: read_next = status_word;
            `PSG_OFF_IRQ_STAT: read_next = {28'h0, irq_stat_reg};
            `PSG_OFF_IRQ_MASK: read_next = {28'h0, irq_mask_reg};
            default: read_next = 32'h0;
        endcase
    end

    // Read data captured in the wait cycle, shown when pready rises
    always @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            prdata_out <= 32'h0;
        end else if (rd_capture) begin
            prdata_out <= read_next;
        end
    end

endmodule // psg_guard

// >>> bench/psg_guard_asserts.sv
// Checker for the guard: pin levels against stage outputs.
// Assumes the guard's sync latency; runs of 5 samples cover it.
`timescale 1ns/1ps
module psg_guard_asserts (
    input wire mclk_in,
    input wire sys_rst_in,
    input wire pair_one_hold_n_in,
    input wire pair_two_hold_n_in,
    input wire gate_drive_supply_ok_in,
    input wire overtemp_in,
    input wire overload_one_in,
    input wire [3:0] high_side_on_out,
    input wire [3:0] low_side_on_out,
    input wire [3:0] weak_pulldown_out,
    input wire fault_flag_n_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    wire h1 = pair_one_hold_n_in;
    wire h2 = pair_two_hold_n_in;
    wire [3:0] on = high_side_on_out | low_side_on_out;
    wire fn = fault_flag_n_out;
    property p_uv;
        (!gate_drive_supply_ok_in && h1 && h2)[*5] |-> on == 4'h0 && !fn;
    endproperty
    a_uv: assert property (p_uv) else $error("stage live in undervoltage");
    property p_h1;
        (!h1)[*5] |-> on[1:0] == 2'h0;
    endproperty
    a_h1: assert property (p_h1) else $error("pair one switching");
    property p_h2;
        (!h2)[*5] |-> on[3:2] == 2'h0;
    endproperty
    a_h2: assert property (p_h2) else $error("pair two switching");
    property p_fhi;
        (!h1 || !h2)[*5] |-> fn;
    endproperty
    a_fhi: assert property (p_fhi) else $error("fault shown while held");
    property p_pd;
        h1[*5] |-> weak_pulldown_out[1:0] == 2'h0;
    endproperty
    a_pd: assert property (p_pd) else $error("pulldown on while running");
    property p_ovl;
        (overload_one_in && h1 && h2)[*5] |-> on[1:0] == 2'h0 && !fn;
    endproperty
    a_ovl: assert property (p_ovl) else $error("overload not shut down");
    property p_ot;
        (overtemp_in && h1 && h2)[*5] |-> on == 4'h0 && !fn;
    endproperty
    a_ot: assert property (p_ot) else $error("overtemp not shut down");
    property p_latch;
        (overload_one_in && h1 && h2)[*5] ##1 (h1 && h2)[*4] |-> on[1:0] == 2'h0;
    endproperty
    a_latch: assert property (p_latch) else $error("overload not latched");
    c_uv: cover property (!gate_drive_supply_ok_in && h1 && h2);
    c_ovl: cover property (overload_one_in && h1 && h2);
    c_ot: cover property (overtemp_in && h1 && h2);
endmodule // psg_guard_asserts
bind psg_guard psg_guard_asserts psg_guard_asserts_inst (.*);

// >>> bench/psg_ctrl_model.sv
// Modulator and controller model: drives pair holds and PWM.
// Assumes the guard's clock; WAIT_CYC stands for a shortened 4 ms.
`timescale 1ns/1ps
module psg_ctrl_model #(
    parameter WAIT_CYC = 40
) (
    input wire clk_in,
    input wire fault_flag_n_in,
    input wire [1:0] hold_req_in,
    output reg [1:0] hold_n_out,
    output reg [3:0] pwm_out
);
    reg [1:0] ph = 2'h0;
    reg fault_prev = 1'b1;
    integer since_fall = 0;
    initial hold_n_out = 2'h0;
    initial pwm_out = 4'h0;
    always @(posedge clk_in) begin
        ph <= ph + 2'h1;
        fault_prev <= fault_flag_n_in;
        if (fault_prev && !fault_flag_n_in)
            since_fall <= 0;
        else
            since_fall <= since_fall + 1;
        if (since_fall >= WAIT_CYC)
            hold_n_out <= hold_req_in;
        else
            hold_n_out <= hold_n_out & hold_req_in;
        // PWM low while held, so low at release
        pwm_out <= {~ph[1], ph[1], ~ph[1], ph[1]} &
            {{2{hold_n_out[1]}}, {2{hold_n_out[0]}}};
    end
endmodule // psg_ctrl_model

// >>> bench/psg_guard_test.sv
// Testbench for the guard: APB tasks and pin scenarios.
// Assumes the controller model drives holds and PWM.
`timescale 1ns/1ps
`include "psg_consts.vh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
 bad_count++; $display("wrong value t=%0t got %h exp %h", $time, a, b); \
 end end
module psg_guard_test;
    reg mclk_in = 0, sys_rst_in = 1, psel = 0, pen = 0, pwr = 0, e;
    reg [11:0] pa = 0;
    reg [31:0] pwd = 0, rdat;
    reg gok = 1, cok = 1, ot = 0, ov1 = 0, ov2 = 0;
    reg [1:0] req = 0;
    wire [1:0] hn;
    wire [3:0] pwm, hs, ls, pd;
    wire [3:0] on = hs | ls;
    wire rdy, err, fn, irq;
    wire [31:0] prd;
    integer bad_count = 0, samples_checked = 0, m;
    always #12.5 mclk_in = ~mclk_in;
    psg_guard psg_guard_inst (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa),
        .pwdata_in(pwd), .pstrb_in(4'hF), .pready_out(rdy),
        .prdata_out(prd), .pslverr_out(err), .pair_one_hold_n_in(hn[0]),
        .pair_two_hold_n_in(hn[1]), .gate_drive_supply_ok_in(gok),
        .core_supply_ok_in(cok), .overtemp_in(ot), .overload_one_in(ov1),
        .overload_two_in(ov2), .pwm_in(pwm), .high_side_on_out(hs),
        .low_side_on_out(ls), .weak_pulldown_out(pd),
        .fault_flag_n_out(fn), .irq_out(irq));
    psg_ctrl_model psg_ctrl_model_inst (.clk_in(mclk_in),
        .fault_flag_n_in(fn), .hold_req_in(req), .hold_n_out(hn),
        .pwm_out(pwm));
    task apb(input reg w, input reg [11:0] a, input reg [31:0] d);
        begin
            @(posedge mclk_in);
            psel <= 1; pwr <= w; pa <= a; pwd <= d;
            @(posedge mclk_in) pen <= 1;
            do @(posedge mclk_in); while (rdy !== 1'b1);
            rdat = prd; e = err;
            psel <= 0; pen <= 0;
        end
    endtask
    task cyc(input integer n);
        begin
            repeat (n) @(posedge mclk_in);
            @(negedge mclk_in);
        end
    endtask
    task summarize;
        begin
            $display("checks %0d errors %0d", samples_checked, bad_count);
            if (bad_count == 0 && samples_checked > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    initial begin
        repeat (5000) @(posedge mclk_in);
        bad_count++;
        summarize;
    end
    initial begin
        repeat (10) @(posedge mclk_in);
        sys_rst_in <= 0;
        cyc(4);
        apb(0, `PSG_OFF_STATUS, 0); `CHK(rdat, 32'h30)
        apb(0, `PSG_OFF_CTRL, 0); `CHK(rdat, 32'h0)
        cyc(1); `CHK(on, 4'h0)
        for (m = 0; m < 3; m++) begin
            apb(1, `PSG_OFF_CTRL, m); cyc(3);
            `CHK(pd, (m == 2) ? 4'h0 : 4'hF)
        end
        apb(1, `PSG_OFF_CTRL, 0); apb(1, `PSG_OFF_IRQ_MASK, 32'hF);
        @(posedge mclk_in) req <= 2'b11; cyc(50);
        `CHK({on, fn, pd}, 9'h1F0)
        @(posedge mclk_in) gok <= 0; cyc(6);
        `CHK({on, fn, irq}, 6'h01)
        @(posedge mclk_in) gok <= 1; cyc(6); `CHK({on, fn}, 5'h1F)
        apb(1, `PSG_OFF_IRQ_STAT, 32'hF); cyc(2); `CHK(irq, 1'b0)
        @(posedge mclk_in) ov1 <= 1; cyc(6);
        @(posedge mclk_in) ov1 <= 0; cyc(6); `CHK({on, fn}, 5'h18)
        apb(0, `PSG_OFF_IRQ_STAT, 0); `CHK(rdat, 32'h4)
        @(posedge mclk_in) req <= 2'b10; cyc(4); `CHK(fn, 1'b1)
        @(posedge mclk_in) req <= 2'b11; cyc(6); `CHK(on, 4'hC)
        cyc(40); `CHK({on, fn}, 5'h1F)
        @(posedge mclk_in) ot <= 1; cyc(6);
        @(posedge mclk_in) ot <= 0; cyc(6); `CHK({on, fn}, 5'h00)
        @(posedge mclk_in) req <= 2'b01; cyc(6); `CHK(on, 4'h3)
        @(posedge mclk_in) req <= 2'b11; cyc(50);
        `CHK({on, fn}, 5'h1F)
        `CHK(hs & ls, 4'h0)
        @(posedge mclk_in) ov2 <= 1; cyc(6);
        @(posedge mclk_in) ov2 <= 0; cyc(6); `CHK({on, fn}, 5'h06)
        @(posedge mclk_in) req <= 2'b01; cyc(2);
        @(posedge mclk_in) req <= 2'b11; cyc(50);
        `CHK({on, fn}, 5'h1F)
        apb(1, `PSG_OFF_IRQ_STAT, 32'hF); apb(1, `PSG_OFF_IRQ_MASK, 0);
        @(posedge mclk_in) cok <= 0; cyc(6); `CHK({fn, irq}, 2'b00)
        @(posedge mclk_in) cok <= 1; cyc(6);
        apb(0, 12'h010, 0); `CHK({e, rdat}, {1'b1, 32'h0})
        summarize;
    end
endmodule // psg_guard_test
